// >>> rtl/bus_status_pkg.sv
// Constants and types shared by both ends of the bus status link.
// Assumes one clock, mclk_in, for both ends.
// How it works
// - Drive cycle code during T4, T1, T2
// - Passive code in T3; a wait state holds the code until ready is seen
// - Leaving passive in T4 starts cycle
// - Return to passive ends cycle
// - Controller decodes every command from status
// - Status floats while bus is granted
// - First reset clock drives status high
// - Status floats for rest of reset
// - Strap tied low selects status mode
// - Eight codes, passive is all ones
package bus_status_pkg;
    localparam int       ST_W        = 3;
    localparam int       CMD_W       = 5;
    // Status codes, bit2 first
    localparam logic [2:0] ST_INT_ACK = 3'h0;
    localparam logic [2:0] ST_IO_RD   = 3'h1;
    localparam logic [2:0] ST_IO_WR   = 3'h2;
    localparam logic [2:0] ST_HALT    = 3'h3;
    localparam logic [2:0] ST_CODE    = 3'h4;
    localparam logic [2:0] ST_MEM_RD  = 3'h5;
    localparam logic [2:0] ST_MEM_WR  = 3'h6;
    localparam logic [2:0] ST_PASSIVE = 3'h7;
    // Command strobe positions
    localparam int       CMD_INTA    = 0;
    localparam int       CMD_IORD    = 1;
    localparam int       CMD_IOWR    = 2;
    localparam int       CMD_MRD     = 3;
    localparam int       CMD_MWR     = 4;
    localparam logic [4:0] CMD_NONE  = 5'h00;
    // Strap level selecting status mode
    localparam logic     STRAP_STATUS_MODE = 1'b0;
    // Clock phase within a bus state
    localparam logic     PH_HIGH     = 1'b1;
    localparam logic     PH_LOW      = 1'b0;

    typedef enum logic [2:0] {
        TS_IDLE,
        TS_T1,
        TS_T2,
        TS_T3,
        TS_TW,
        TS_T4,
        TS_HOLD,
        TS_RST
    } bus_state_t;

    typedef enum logic [1:0] {
        CS_IDLE,
        CS_CMD,
        CS_HALT
    } ctl_state_t;

    // Command strobes decoded from a status code
    function automatic logic [4:0] decode_cmd(input logic [2:0] code);
        logic [4:0] c;
        c = CMD_NONE;
        case (code)
            ST_INT_ACK: c[CMD_INTA] = 1'b1;
            ST_IO_RD:   c[CMD_IORD] = 1'b1;
            ST_IO_WR:   c[CMD_IOWR] = 1'b1;
            ST_CODE,
            ST_MEM_RD:  c[CMD_MRD]  = 1'b1;
            ST_MEM_WR:  c[CMD_MWR]  = 1'b1;
            default:    c = CMD_NONE;
        endcase
        return c;
    endfunction
endpackage

// >>> rtl/bus_status_if.sv
// Status link between the processor end and the bus controller end.
// Assumes a pull-up on each status line: a floating line reads high.
interface bus_status_if;
    import bus_status_pkg::*;
    logic [2:0] bus_status_drv;   // bit2..bit0 driven value
    logic       bus_status_oe;
    logic [2:0] bus_status_level; // level seen on the wires
    logic       bus_grant_ack;
    logic       ready;
    logic       mode_select_strap;

    assign bus_status_level = bus_status_oe ? bus_status_drv : ST_PASSIVE;

    modport dev_mp (
        output bus_status_drv,
        output bus_status_oe,
        output bus_grant_ack,
        input  ready,
        input  mode_select_strap
    );

    modport ctl_mp (
        input  bus_status_level,
        input  bus_grant_ack,
        output ready,
        output mode_select_strap
    );
endinterface

// >>> rtl/bus_status_encoder.sv
// Processor end: runs bus states and drives the three status lines.
// Assumes ready and the strap are synchronous to mclk_in.
// Each bus state lasts two mclk cycles: high half, then low half.
// Cycle walk: T4 code out, T1 and T2 held, ready checked at T2 end,
// TW repeats until ready, T3 passive with the next code loaded.
// An idle request uses its start slot as the opening T4.
// Hold is granted only from idle or from a T4 with nothing pending.
module bus_status_encoder
    import bus_status_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       rstn_in,
    input  wire logic       cpu_reset_in,
    input  wire logic       req_valid_in,
    input  wire logic [2:0] req_code_in,
    input  wire logic       hold_req_in,
    output logic            req_taken_out,
    output logic            cycle_done_out,
    output logic            grant_ack_out,
    output logic            status_mode_out,
    bus_status_if.dev_mp    link
);
    typedef struct packed {
        bus_state_t state;
        logic       phase;
        logic [2:0] code;
        logic       pend;
        logic [2:0] st_out;
        logic       st_oe;
        logic       grant;
        logic       in_rst;
        logic       stat_mode;
        logic       taken;
        logic       done;
    } enc_state_t;

    enc_state_t r_reg;
    enc_state_t r_next;

    // Opens a bus cycle; its first state acts as T4
    function automatic enc_state_t launch_cycle(
        input enc_state_t s,
        input logic [2:0] c
    );
        enc_state_t n;
        n        = s;
        n.code   = c;
        n.st_out = c;
        n.st_oe  = 1'b1;
        n.taken  = 1'b1;
        n.pend   = 1'b1;
        n.state  = TS_T4;
        return n;
    endfunction

    // Hands the bus over: lines float while granted
    function automatic enc_state_t enter_hold(
        input enc_state_t s
    );
        enc_state_t n;
        n       = s;
        n.grant = 1'b1;
        n.st_oe = 1'b0;
        n.state = TS_HOLD;
        return n;
    endfunction

    // Status back to passive marks the end of the cycle
    function automatic enc_state_t end_cycle(
        input enc_state_t s
    );
        enc_state_t n;
        n        = s;
        n.st_out = ST_PASSIVE;
        n.done   = 1'b1;
        return n;
    endfunction

    // Lines driven passive again, ready for a new cycle
    function automatic enc_state_t drive_idle(
        input enc_state_t s
    );
        enc_state_t n;
        n        = s;
        n.st_out = ST_PASSIVE;
        n.st_oe  = 1'b1;
        n.state  = TS_IDLE;
        return n;
    endfunction

    always_comb begin
        r_next       = r_reg;
        r_next.taken = 1'b0;
        r_next.done  = 1'b0;
        r_next.phase = ~r_reg.phase;
        if (cpu_reset_in) begin
            r_next.grant     = 1'b0;
            r_next.pend      = 1'b0;
            r_next.stat_mode = (link.mode_select_strap == STRAP_STATUS_MODE);
            r_next.phase     = PH_HIGH;
            r_next.state     = TS_RST;
            if (!r_reg.in_rst) begin
                r_next.in_rst = 1'b1;
                r_next.st_out = ST_PASSIVE;
                r_next.st_oe  = 1'b1;
            end else begin
                r_next.st_oe  = 1'b0;
            end
        end else if (!r_reg.stat_mode) begin
            r_next.in_rst = 1'b0;
            r_next.st_oe  = 1'b0;
            r_next.state  = TS_IDLE;
        end else if (r_reg.phase == PH_HIGH) begin
            // Ready seen high inside a wait state ends the cycle now
            if (r_reg.state == TS_TW && link.ready
                    && r_reg.st_out != ST_PASSIVE) begin
                r_next = end_cycle(r_next);
            end
        end else begin
            case (r_reg.state)
                TS_RST: begin
                    r_next.in_rst = 1'b0;
                    r_next        = drive_idle(r_next);
                end

                TS_IDLE: begin
                    if (hold_req_in) begin
                        r_next = enter_hold(r_next);
                    end else if (req_valid_in) begin
                        // Start slot acts as the opening T4
                        r_next = launch_cycle(r_next, req_code_in);
                    end
                end

                TS_T4: begin
                    if (r_reg.pend) begin
                        r_next.pend  = 1'b0;
                        r_next.state = TS_T1;
                    end else if (hold_req_in) begin
                        r_next = enter_hold(r_next);
                    end else begin
                        r_next.state = TS_IDLE;
                    end
                end

                TS_T1: begin
                    r_next.state = TS_T2;
                end

                TS_T2: begin
                    if (link.ready) begin
                        r_next       = end_cycle(r_next);
                        r_next.state = TS_T3;
                    end else begin
                        r_next.state = TS_TW;
                    end
                end

                TS_TW: begin
                    if (r_reg.st_out == ST_PASSIVE) begin
                        r_next.state = TS_T3;
                    end
                end

                TS_T3: begin
                    r_next.state = TS_T4;
                    if (req_valid_in && !hold_req_in) begin
                        // Back to back: next code in this T4
                        r_next = launch_cycle(r_next, req_code_in);
                    end
                end

                TS_HOLD: begin
                    if (!hold_req_in) begin
                        r_next.grant = 1'b0;
                        r_next       = drive_idle(r_next);
                    end else begin
                        r_next.st_oe = 1'b0;
                    end
                end

                default: begin
                    r_next.state = TS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            r_reg.state     <= TS_IDLE;
            r_reg.phase     <= PH_HIGH;
            r_reg.code      <= ST_PASSIVE;
            r_reg.pend      <= 1'b0;
            r_reg.st_out    <= ST_PASSIVE;
            r_reg.st_oe     <= 1'b0;
            r_reg.grant     <= 1'b0;
            r_reg.in_rst    <= 1'b0;
            r_reg.stat_mode <= 1'b0;
            r_reg.taken     <= 1'b0;
            r_reg.done      <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.bus_status_drv = r_reg.st_out;
    assign link.bus_status_oe  = r_reg.st_oe;
    assign link.bus_grant_ack  = r_reg.grant;
    assign req_taken_out       = r_reg.taken;
    assign cycle_done_out      = r_reg.done;
    assign grant_ack_out       = r_reg.grant;
    assign status_mode_out     = r_reg.stat_mode;
endmodule

// >>> rtl/bus_status_controller.sv
// Bus controller end: turns status transitions into command strobes.
// Assumes the status lines read high while nobody drives them.
module bus_status_controller
    import bus_status_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       rstn_in,
    input  wire logic       ready_in,
    output logic            int_ack_cmd_out,
    output logic            io_read_cmd_out,
    output logic            io_write_cmd_out,
    output logic            mem_read_cmd_out,
    output logic            mem_write_cmd_out,
    output logic            halt_seen_out,
    output logic            cycle_start_out,
    output logic            cycle_end_out,
    output logic [2:0]      cycle_code_out,
    bus_status_if.ctl_mp    link
);
    typedef struct packed {
        ctl_state_t state;
        logic [2:0] prev;
        logic [2:0] code;
        logic [4:0] cmd;
        logic       halt;
        logic       start;
        logic       fin;
        logic       rdy;
        logic       strap;
    } ctl_reg_t;

    ctl_reg_t r_reg;
    ctl_reg_t r_next;

    always_comb begin
        r_next       = r_reg;
        r_next.start = 1'b0;
        r_next.fin   = 1'b0;
        r_next.halt  = 1'b0;
        r_next.prev  = link.bus_status_level;
        r_next.rdy   = ready_in;
        r_next.strap = STRAP_STATUS_MODE;
        case (r_reg.state)
            CS_IDLE: begin
                if (r_reg.prev == ST_PASSIVE
                        && link.bus_status_level != ST_PASSIVE) begin
                    r_next.start = 1'b1;
                    r_next.code  = link.bus_status_level;
                    r_next.cmd   = decode_cmd(link.bus_status_level);
                    r_next.halt  = (link.bus_status_level == ST_HALT);
                    r_next.state = CS_CMD;
                end
            end
            CS_CMD: begin
                if (link.bus_status_level == ST_PASSIVE) begin
                    r_next.fin   = 1'b1;
                    r_next.cmd   = CMD_NONE;
                    r_next.state = CS_IDLE;
                end
            end
            default: begin
                r_next.cmd   = CMD_NONE;
                r_next.state = CS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            r_reg.state <= CS_IDLE;
            r_reg.prev  <= ST_PASSIVE;
            r_reg.code  <= ST_PASSIVE;
            r_reg.cmd   <= CMD_NONE;
            r_reg.halt  <= 1'b0;
            r_reg.start <= 1'b0;
            r_reg.fin   <= 1'b0;
            r_reg.rdy   <= 1'b0;
            r_reg.strap <= STRAP_STATUS_MODE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign int_ack_cmd_out        = r_reg.cmd[CMD_INTA];
    assign io_read_cmd_out        = r_reg.cmd[CMD_IORD];
    assign io_write_cmd_out       = r_reg.cmd[CMD_IOWR];
    assign mem_read_cmd_out       = r_reg.cmd[CMD_MRD];
    assign mem_write_cmd_out      = r_reg.cmd[CMD_MWR];
    assign halt_seen_out          = r_reg.halt;
    assign cycle_start_out        = r_reg.start;
    assign cycle_end_out          = r_reg.fin;
    assign cycle_code_out         = r_reg.code;
    assign link.ready             = r_reg.rdy;
    assign link.mode_select_strap = r_reg.strap;
endmodule

// >>> testbench/bus_status_checker.sv
// Timing checks on the status link between the two ends.
// Assumes it is wired to the interface signals, one clock domain.
module bus_status_checker
    import bus_status_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       rstn_in,
    input  wire logic [2:0] bus_status_drv,
    input  wire logic       bus_status_oe,
    input  wire logic [2:0] bus_status_level,
    input  wire logic       bus_grant_ack,
    input  wire logic       ready,
    input  wire logic       mode_select_strap
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_start;
        bus_status_level != ST_PASSIVE
            && $past(bus_status_level) == ST_PASSIVE;
    endsequence
    sequence s_end;
        bus_status_level == ST_PASSIVE && bus_status_oe
            && $past(bus_status_level) != ST_PASSIVE;
    endsequence

    AST_CODE_HOLDS: assert property (s_start |=>
        $stable(bus_status_level) [*5])
        else $error("Status code changed early in a cycle");
    AST_CYCLE_ENDS: assert property (s_start |-> ##[6:1000] s_end)
        else $error("Bus cycle never returned to passive");
    AST_END_READY: assert property (s_end |->
        $past(ready) || $past(ready, 2))
        else $error("Status went passive without ready");
    AST_PASSIVE_GAP: assert property (s_end |=>
        bus_status_level == ST_PASSIVE)
        else $error("New cycle started in the end state");
    AST_HOLD_FLOAT: assert property (bus_grant_ack |-> !bus_status_oe)
        else $error("Status driven while bus granted");
    AST_GRANT_RISE: assert property ($rose(bus_grant_ack) |->
        $fell(bus_status_oe))
        else $error("Status not released with grant");
    AST_GRANT_FALL: assert property ($fell(bus_grant_ack) |->
        bus_status_oe && bus_status_drv == ST_PASSIVE)
        else $error("Status not passive after grant ends");
    AST_STRAP_LOW: assert property (
        mode_select_strap == STRAP_STATUS_MODE)
        else $error("Mode strap not at status level");
endmodule

// >>> testbench/testbench.sv
// Bench for the status link: both ends joined, user sides driven.
// Assumes package, interface and both ends are compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import bus_status_pkg::*;
    logic       mclk_in = 0;
    logic       rstn_in = 0;
    logic       cpu_reset_in = 0;
    logic       req_valid_in = 0;
    logic [2:0] req_code_in = 3'h0;
    logic       hold_req_in = 0;
    logic       ready_in = 1;
    logic       taken, done, grant, smode, inta, iord, iowr, mrd, mwr;
    logic       halt_s, c_start, c_end, got_halt;
    logic [2:0] c_code, got_code;
    logic [4:0] got_cmd;
    int         error_cnt = 0, n_tests = 0, ends = 0, takes = 0, n, t0;

    bus_status_if bus_if();
    bus_status_encoder i_bus_status_encoder (.mclk_in(mclk_in),
        .rstn_in(rstn_in), .cpu_reset_in(cpu_reset_in),
        .req_valid_in(req_valid_in), .req_code_in(req_code_in),
        .hold_req_in(hold_req_in), .req_taken_out(taken),
        .cycle_done_out(done), .grant_ack_out(grant),
        .status_mode_out(smode), .link(bus_if));
    bus_status_controller i_bus_status_controller (.mclk_in(mclk_in),
        .rstn_in(rstn_in), .ready_in(ready_in), .int_ack_cmd_out(inta),
        .io_read_cmd_out(iord), .io_write_cmd_out(iowr),
        .mem_read_cmd_out(mrd), .mem_write_cmd_out(mwr),
        .halt_seen_out(halt_s), .cycle_start_out(c_start),
        .cycle_end_out(c_end), .cycle_code_out(c_code), .link(bus_if));
    bus_status_checker i_bus_status_checker (.mclk_in(mclk_in),
        .rstn_in(rstn_in), .bus_status_drv(bus_if.bus_status_drv),
        .bus_status_oe(bus_if.bus_status_oe),
        .bus_status_level(bus_if.bus_status_level),
        .bus_grant_ack(bus_if.bus_grant_ack), .ready(bus_if.ready),
        .mode_select_strap(bus_if.mode_select_strap));

    always #2 mclk_in = ~mclk_in;

    always @(posedge mclk_in) begin
        if (c_start === 1'b1) begin
            got_code <= c_code;
            got_cmd <= {mwr, mrd, iowr, iord, inta};
            got_halt <= halt_s;
        end
        if (c_end === 1'b1) ends <= ends + 1;
        if (taken === 1'b1) takes <= takes + 1;
    end

    function automatic logic [4:0] exp_cmd(input logic [2:0] c);
        case (c)
            3'h0: return 5'h01;
            3'h1: return 5'h02;
            3'h2: return 5'h04;
            3'h4, 3'h5: return 5'h08;
            3'h6: return 5'h10;
            default: return 5'h00;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Bounded wait on a pulse; n is the count of edges waited
    task automatic wait_pulse(input bit on_done);
        n = 0;
        do begin
            @(posedge mclk_in);
            #1;
            n++;
        end while ((on_done ? done : taken) !== 1'b1 && n < 40);
    endtask

    task automatic run_cycle(input logic [2:0] code, input int waits);
        @(negedge mclk_in);
        req_valid_in = 1;
        req_code_in = code;
        wait_pulse(0);
        @(negedge mclk_in);
        req_valid_in = 0;
        ready_in = (waits == 0);
        fork
            if (waits > 0) begin
                repeat (waits) @(negedge mclk_in);
                ready_in = 1;
            end
            wait_pulse(1);
        join
        if (waits == 0) chk("cycle length", 8'h06, n[7:0]);
        else chk("wait stretch", 8'h0b, n[7:0]);
        repeat (4) @(posedge mclk_in);
        #1;
        chk("cycle code", {5'h00, code}, {5'h00, got_code});
        chk("strobes", {3'h0, exp_cmd(code)}, {3'h0, got_cmd});
        chk("halt flag", {7'h00, code == ST_HALT}, {7'h00, got_halt});
        chk("strobes off", 8'h00, {3'h0, mwr, mrd, iowr, iord, inta});
    endtask

    initial begin
        #20000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge mclk_in);
        @(negedge mclk_in);
        rstn_in = 1;
        cpu_reset_in = 1;
        @(posedge mclk_in);
        #1;
        chk("reset drive", 8'h0f, {4'h0, bus_if.bus_status_oe,
            bus_if.bus_status_level});
        @(posedge mclk_in);
        #1;
        chk("reset float", 8'h07, {4'h0, bus_if.bus_status_oe,
            bus_if.bus_status_level});
        repeat (3) @(negedge mclk_in);
        cpu_reset_in = 0;
        repeat (4) @(posedge mclk_in);
        #1;
        chk("status mode", 8'h01, {7'h00, smode});
        for (int c = 0; c < 7; c++) run_cycle(c[2:0], 0);
        run_cycle(ST_MEM_WR, 8);
        chk("cycle ends", 8'h08, ends[7:0]);
        @(negedge mclk_in);
        req_valid_in = 1;
        req_code_in = ST_IO_RD;
        wait_pulse(0);
        wait_pulse(0);
        chk("back to back", 8'h08, n[7:0]);
        @(negedge mclk_in);
        req_valid_in = 0;
        repeat (12) @(posedge mclk_in);
        @(negedge mclk_in);
        hold_req_in = 1;
        req_valid_in = 1;
        req_code_in = ST_CODE;
        t0 = takes;
        repeat (10) @(posedge mclk_in);
        #1;
        chk("hold float", 8'h17, {3'h0, grant, bus_if.bus_status_oe,
            bus_if.bus_status_level});
        chk("held off", t0[7:0], takes[7:0]);
        @(negedge mclk_in);
        hold_req_in = 0;
        wait_pulse(0);
        chk("taken after hold", 8'h01, {7'h00, taken});
        @(negedge mclk_in);
        req_valid_in = 0;
        repeat (12) @(posedge mclk_in);
        report_and_stop();
    end
endmodule
